// ---- design/diag_regs_cfg.svh ----
// Offsets, field positions, reset values and fixed counts of the diagnostic register bank.
// Assumes byte offsets on a 32-bit register bus with word addressing.
`ifndef DIAG_REGS_CFG_SVH
`define DIAG_REGS_CFG_SVH

`define OFS_PHY_OPT 18'h00F10
`define OFS_RXH 18'h02410
`define OFS_RXT 18'h02418
`define OFS_RXHS 18'h02420
`define OFS_RXTS 18'h02428
`define OFS_RXPC 18'h02430
`define OFS_TXH 18'h03410
`define OFS_RXH_ALIAS 18'h08000
`define OFS_RXT_ALIAS 18'h08008
`define OFS_TXH_ALIAS 18'h08010

`define PO_ALWAYS_LPL 1
`define PO_LPL 2
`define PO_GIG_DIS_NA 3
`define PO_DRV_CLASS 4
`define PO_RENEG 5
`define PO_GIG_DIS 6
`define PO_AUTO_UPD_DIS 7
`define PO_PAUSE_SYM 8
`define PO_PAUSE_ASYM 9
`define PO_W 10
`define PO_NVM_W 8
`define PO_RST 10'h30D

`define PTR_W 13
`define PTR_RST 13'h0000
`define RXA_DEFAULT 6'h0C
`define RXA_SCALE 128
`define TXH_RST 13'h0600

`define PI_RXH 0
`define PI_RXT 1
`define PI_RXHS 2
`define PI_RXTS 3
`define PI_RXPC 4
`define PI_TXH 5
`define PI_N 6

`endif

// ---- design/diag_regs_pkg.sv ----
// Types shared by the diagnostic register bank.
// Assumes diag_regs_cfg.svh for widths.
`include "diag_regs_cfg.svh"
package diag_regs_pkg;
    typedef logic [`PTR_W-1:0] ptr_t;
    typedef logic [`PO_W-1:0] phy_opt_t;
    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_ACK = 2'b01
    } bus_state_e;
endpackage

// ---- design/ptr_if.sv ----
// Carrier between the bank and one pointer register cell.
// Assumes one writer on each side of the modports.
`timescale 1ns/1ps
`default_nettype none
interface ptr_if;
    import diag_regs_pkg::*;
    logic sw_we;
    ptr_t sw_data;
    logic hw_we;
    ptr_t hw_data;
    ptr_t value;
    modport keeper(input sw_we, input sw_data, input hw_we, input hw_data, output value);
    modport user(output sw_we, output sw_data, output hw_we, output hw_data, input value);
endinterface
`default_nettype wire

// ---- design/ptr_reg_cell.sv ----
// One FIFO pointer or count register with software and hardware load paths.
// Assumes mclk and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs_cfg.svh"
module ptr_reg_cell #(
    parameter diag_regs_pkg::ptr_t RST_VAL = `PTR_RST
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    ptr_if.keeper p
);
    import diag_regs_pkg::*;

    // Software write replaces the live value; hardware continues from it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            p.value <= RST_VAL;
        end else if (p.sw_we) begin
            p.value <= p.sw_data;
        end else if (p.hw_we) begin
            p.value <= p.hw_data;
        end
    end

    AST_SW_LOAD: assert property (@(posedge mclk) disable iff (rst)
        p.sw_we |=> p.value == $past(p.sw_data))
        else $error("software write not taken by pointer");
    AST_HW_LOAD: assert property (@(posedge mclk) disable iff (rst)
        (p.hw_we && !p.sw_we) |=> p.value == $past(p.hw_data))
        else $error("hardware update not taken by pointer");
endmodule
`default_nettype wire

// ---- design/packet_buffer_diag_regs.sv ----
// Diagnostic register bank: PHY option bits and packet buffer FIFO pointers.
// Assumes an Avalon-MM master with word addresses and FIFO logic driving update strobes.
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs_cfg.svh"
// Operation
// - Always-low-power bit forces slowest link everywhere.
// - Low-power bit slows link outside full activity.
// - Bit 3 blocks gigabit outside full activity.
// - Bit 6 blocks gigabit in all states.
// - Writing bit 5 restarts auto-negotiation.
// - Bit 7 stops flash auto-update on writes.
// - Bit 8 advertises symmetric pause, resets one.
// - Bit 9 advertises asymmetric pause, resets one.
// - Low option byte loads from nonvolatile word.
// - Receive head: 13-bit word offset, resets zero.
// - Receive tail: 13-bit word offset.
// - Alias addresses reach the same pointer registers.
// - Pointers count from whole buffer start.
// - Saved head and tail copies, reset zero.
// - Receive packet count, 13 bits, resets zero.
// - Transmit head: 13-bit word offset.
// - Transmit head resets to default allocation (12) times 128.
// - Upper pointer bits read zero.
module packet_buffer_diag_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Nonvolatile load and power state
    input wire logic nvm_load,
    input wire logic [7:0] nvm_opt_byte,
    input wire logic fully_active_state,
    // FIFO logic updates
    input wire logic rx_head_upd,
    input wire diag_regs_pkg::ptr_t rx_head_in,
    input wire logic rx_tail_upd,
    input wire diag_regs_pkg::ptr_t rx_tail_in,
    input wire logic rx_ptr_save,
    input wire logic rx_ptr_restore,
    input wire logic rx_pkt_inc,
    input wire logic rx_pkt_dec,
    input wire logic tx_head_upd,
    input wire diag_regs_pkg::ptr_t tx_head_in,
    input wire logic alloc_reload,
    input wire logic [5:0] rx_allocation_size,
    // Pointer values to FIFO logic
    output diag_regs_pkg::ptr_t rx_head,
    output diag_regs_pkg::ptr_t rx_tail,
    output diag_regs_pkg::ptr_t rx_packet_count,
    output diag_regs_pkg::ptr_t tx_head,
    // PHY controls
    output logic phy_slowest_link,
    output logic phy_gigabit_disable,
    output logic phy_autoneg_restart,
    output logic phy_pause_sym,
    output logic phy_pause_asym,
    output logic line_driver_class,
    output logic flash_auto_update_disable
);
    import diag_regs_pkg::*;

    bus_state_e state_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    phy_opt_t opt_ff;
    logic reneg_ff;
    logic slow_ff;
    logic gig_dis_ff;
    logic pause_sym_ff;
    logic pause_asym_ff;
    logic drv_class_ff;
    logic upd_dis_ff;
    logic [17:0] byte_addr;
    logic req;
    logic acc_wr;
    logic hit_opt;
    logic [`PI_N-1:0] hit;
    logic [31:0] nxt_rdata;
    logic [31:0] wmask;
    ptr_t live [`PI_N];
    ptr_t tx_alloc_ptr;

    ptr_if pif [`PI_N] ();

    assign byte_addr = {avs_address, 2'b00};
    assign req = avs_read | avs_write;
    assign acc_wr = avs_write & (state_ff == BS_ACK);
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign tx_alloc_ptr = ptr_t'(rx_allocation_size * `RXA_SCALE);

    // Address decode, aliases included
    always_comb begin
        hit_opt = 1'b0;
        hit = '0;
        unique case (byte_addr)
            `OFS_PHY_OPT: hit_opt = 1'b1;
            `OFS_RXH, `OFS_RXH_ALIAS: hit[`PI_RXH] = 1'b1;
            `OFS_RXT, `OFS_RXT_ALIAS: hit[`PI_RXT] = 1'b1;
            `OFS_RXHS: hit[`PI_RXHS] = 1'b1;
            `OFS_RXTS: hit[`PI_RXTS] = 1'b1;
            `OFS_RXPC: hit[`PI_RXPC] = 1'b1;
            `OFS_TXH, `OFS_TXH_ALIAS: hit[`PI_TXH] = 1'b1;
            default: hit_opt = 1'b0;
        endcase
    end

    // Read mux; unmapped and reserved bits return zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hit_opt) begin
            nxt_rdata[`PO_W-1:0] = opt_ff;
        end
        for (int i = 0; i < `PI_N; i++) begin
            if (hit[i]) begin
                nxt_rdata[`PTR_W-1:0] = live[i];
            end
        end
    end

    // One wait cycle: request seen, then answered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= BS_IDLE;
            wait_ff <= 1'b1;
        end else begin
            unique case (state_ff)
                BS_IDLE: begin
                    if (req) begin
                        state_ff <= BS_ACK;
                        wait_ff <= 1'b0;
                    end
                end
                BS_ACK: begin
                    state_ff <= BS_IDLE;
                    wait_ff <= 1'b1;
                end
                default: begin
                    state_ff <= BS_IDLE;
                    wait_ff <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && state_ff == BS_IDLE) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;

    // Option register; re-negotiation bit is a command and never stored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            opt_ff <= `PO_RST;
        end else if (acc_wr && hit_opt) begin
            opt_ff <= (opt_ff & ~wmask[`PO_W-1:0])
                | (avs_writedata[`PO_W-1:0] & wmask[`PO_W-1:0]);
            opt_ff[`PO_RENEG] <= 1'b0;
        end else if (nvm_load) begin
            opt_ff[`PO_NVM_W-1:0] <= nvm_opt_byte;
            opt_ff[`PO_RENEG] <= 1'b0;
        end
    end

    // Restart pulse on a write that sets the command bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reneg_ff <= 1'b0;
        end else begin
            reneg_ff <= acc_wr & hit_opt & avs_byteenable[0]
                & avs_writedata[`PO_RENEG];
        end
    end

    // Link speed resolution from option bits and power state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            slow_ff <= 1'b0;
            gig_dis_ff <= 1'b0;
        end else begin
            slow_ff <= opt_ff[`PO_ALWAYS_LPL]
                | (opt_ff[`PO_LPL] & ~fully_active_state);
            gig_dis_ff <= opt_ff[`PO_GIG_DIS]
                | (opt_ff[`PO_GIG_DIS_NA] & ~fully_active_state);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pause_sym_ff <= 1'b1;
            pause_asym_ff <= 1'b1;
            drv_class_ff <= 1'b0;
            upd_dis_ff <= 1'b0;
        end else begin
            pause_sym_ff <= opt_ff[`PO_PAUSE_SYM];
            pause_asym_ff <= opt_ff[`PO_PAUSE_ASYM];
            drv_class_ff <= opt_ff[`PO_DRV_CLASS];
            upd_dis_ff <= opt_ff[`PO_AUTO_UPD_DIS];
        end
    end

    assign phy_slowest_link = slow_ff;
    assign phy_gigabit_disable = gig_dis_ff;
    assign phy_autoneg_restart = reneg_ff;
    assign phy_pause_sym = pause_sym_ff;
    assign phy_pause_asym = pause_asym_ff;
    assign line_driver_class = drv_class_ff;
    assign flash_auto_update_disable = upd_dis_ff;

    // Pointer cells; values are whole-buffer word offsets
    for (genvar g = 0; g < `PI_N; g++) begin : g_ptr
        ptr_reg_cell #(
            .RST_VAL((g == `PI_TXH) ? `TXH_RST : `PTR_RST)
        ) u_cell (
            .mclk(mclk),
            .rst(rst),
            .p(pif[g])
        );
        assign live[g] = pif[g].value;
        assign pif[g].sw_we = acc_wr & hit[g];
        assign pif[g].sw_data = (pif[g].value & ~wmask[`PTR_W-1:0])
            | (avs_writedata[`PTR_W-1:0] & wmask[`PTR_W-1:0]);
    end

    // Hardware update paths
    assign pif[`PI_RXH].hw_we = rx_head_upd | rx_ptr_restore;
    assign pif[`PI_RXH].hw_data = rx_ptr_restore ? live[`PI_RXHS] : rx_head_in;
    assign pif[`PI_RXT].hw_we = rx_tail_upd | rx_ptr_restore;
    assign pif[`PI_RXT].hw_data = rx_ptr_restore ? live[`PI_RXTS] : rx_tail_in;
    assign pif[`PI_RXHS].hw_we = rx_ptr_save;
    assign pif[`PI_RXHS].hw_data = live[`PI_RXH];
    assign pif[`PI_RXTS].hw_we = rx_ptr_save;
    assign pif[`PI_RXTS].hw_data = live[`PI_RXT];
    assign pif[`PI_RXPC].hw_we = rx_pkt_inc ^ rx_pkt_dec;
    assign pif[`PI_RXPC].hw_data = rx_pkt_inc ? live[`PI_RXPC] + ptr_t'(1)
        : live[`PI_RXPC] - ptr_t'(1);
    assign pif[`PI_TXH].hw_we = tx_head_upd | alloc_reload;
    assign pif[`PI_TXH].hw_data = alloc_reload ? tx_alloc_ptr : tx_head_in;

    assign rx_head = live[`PI_RXH];
    assign rx_tail = live[`PI_RXT];
    assign rx_packet_count = live[`PI_RXPC];
    assign tx_head = live[`PI_TXH];

    // Checks
    sequence s_opt_write_reneg;
        acc_wr && hit_opt && avs_byteenable[0] && avs_writedata[`PO_RENEG];
    endsequence

    sequence s_one_pulse;
        phy_autoneg_restart ##1 !phy_autoneg_restart;
    endsequence

    AST_BUS_ANSWER: assert property (@(posedge mclk) disable iff (rst)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    AST_BUS_RELEASE: assert property (@(posedge mclk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_RENEG: assert property (@(posedge mclk) disable iff (rst)
        s_opt_write_reneg |=> s_one_pulse)
        else $error("re-negotiation pulse missing or too long");
    AST_RENEG_CAUSE: assert property (@(posedge mclk) disable iff (rst)
        phy_autoneg_restart |-> $past(acc_wr && hit_opt))
        else $error("re-negotiation without a write");
    AST_ALWAYS_SLOW: assert property (@(posedge mclk) disable iff (rst)
        opt_ff[`PO_ALWAYS_LPL] |=> phy_slowest_link)
        else $error("slowest link not forced");
    AST_SLOW_ACTIVE: assert property (@(posedge mclk) disable iff (rst)
        (!opt_ff[`PO_ALWAYS_LPL] && fully_active_state) |=> !phy_slowest_link)
        else $error("slow link while fully active");
    AST_SLOW_IDLE: assert property (@(posedge mclk) disable iff (rst)
        (opt_ff[`PO_LPL] && !fully_active_state) |=> phy_slowest_link)
        else $error("slow link missing outside full activity");
    AST_GIG_NA: assert property (@(posedge mclk) disable iff (rst)
        (opt_ff[`PO_GIG_DIS_NA] && !fully_active_state) |=> phy_gigabit_disable)
        else $error("gigabit not blocked outside full activity");
    AST_GIG_ALL: assert property (@(posedge mclk) disable iff (rst)
        opt_ff[`PO_GIG_DIS] |=> phy_gigabit_disable)
        else $error("gigabit not blocked");
    AST_GIG_OFF: assert property (@(posedge mclk) disable iff (rst)
        (!opt_ff[`PO_GIG_DIS] && (fully_active_state || !opt_ff[`PO_GIG_DIS_NA]))
        |=> !phy_gigabit_disable)
        else $error("gigabit blocked without cause");
    AST_PAUSE: assert property (@(posedge mclk) disable iff (rst)
        ##1 phy_pause_sym == $past(opt_ff[`PO_PAUSE_SYM]))
        else $error("symmetric pause out of step");
    AST_ASYM: assert property (@(posedge mclk) disable iff (rst)
        ##1 phy_pause_asym == $past(opt_ff[`PO_PAUSE_ASYM]))
        else $error("asymmetric pause out of step");
    AST_UPD_DIS: assert property (@(posedge mclk) disable iff (rst)
        ##1 flash_auto_update_disable == $past(opt_ff[`PO_AUTO_UPD_DIS]))
        else $error("flash update disable out of step");
    AST_NVM: assert property (@(posedge mclk) disable iff (rst)
        (nvm_load && !(acc_wr && hit_opt))
        |=> opt_ff[`PO_NVM_W-1:0] == ($past(nvm_opt_byte) & 8'hDF))
        else $error("option byte not loaded");
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (rst)
        (!avs_waitrequest && avs_read && (hit != '0))
        |-> avs_readdata[31:`PTR_W] == '0)
        else $error("reserved pointer bits not zero");
    AST_ALIAS: assert property (@(posedge mclk) disable iff (rst)
        (avs_read && state_ff == BS_IDLE && byte_addr == `OFS_TXH_ALIAS)
        |=> avs_readdata[`PTR_W-1:0] == $past(live[`PI_TXH]))
        else $error("alias read differs from primary");
    AST_SAVE: assert property (@(posedge mclk) disable iff (rst)
        (rx_ptr_save && !(acc_wr && hit[`PI_RXHS]))
        |=> live[`PI_RXHS] == $past(live[`PI_RXH]))
        else $error("saved head not copied");
    AST_COUNT: assert property (@(posedge mclk) disable iff (rst)
        (rx_pkt_inc && !rx_pkt_dec && !(acc_wr && hit[`PI_RXPC]))
        |=> rx_packet_count == $past(rx_packet_count) + ptr_t'(1))
        else $error("packet count did not advance");
endmodule
`default_nettype wire

// ---- dv/packet_buffer_diag_regs_test.sv ----
// Self-checking bench for the diagnostic register bank: register map, PHY controls, FIFO strobes.
// Assumes the design package and the register map header are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs_cfg.svh"
module packet_buffer_diag_regs_test;
    import diag_regs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] avs_address = 16'h0000;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic nvm_load = 1'b0, fully_active_state = 1'b1;
    logic [7:0] nvm_opt_byte = 8'h00;
    logic rx_head_upd = 1'b0, rx_tail_upd = 1'b0, tx_head_upd = 1'b0, alloc_reload = 1'b0;
    logic rx_ptr_save = 1'b0, rx_ptr_restore = 1'b0, rx_pkt_inc = 1'b0, rx_pkt_dec = 1'b0;
    ptr_t rx_head_in = 13'h0000, rx_tail_in = 13'h0000, tx_head_in = 13'h0000;
    logic [5:0] rx_allocation_size = 6'h00;
    ptr_t rx_head, rx_tail, rx_packet_count, tx_head;
    logic phy_slowest_link, phy_gigabit_disable, phy_autoneg_restart, phy_pause_sym;
    logic phy_pause_asym, line_driver_class, flash_auto_update_disable;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h0000_7608;
    logic [31:0] exp_q[$];
    string name_q[$];
    logic [17:0] ofs_tab[6] = '{`OFS_RXH, `OFS_RXT, `OFS_RXHS, `OFS_RXTS, `OFS_RXPC, `OFS_TXH};
    logic [31:0] rst_tab[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, {19'h0, `TXH_RST}};
    logic [17:0] prim_tab[3] = '{`OFS_RXH, `OFS_RXT, `OFS_TXH};
    logic [17:0] alias_tab[3] = '{`OFS_RXH_ALIAS, `OFS_RXT_ALIAS, `OFS_TXH_ALIAS};
    logic [31:0] v[6];
    logic [31:0] w, a, b;
    logic [5:0] sz;

    packet_buffer_diag_regs uut (
        .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nvm_load(nvm_load),
        .nvm_opt_byte(nvm_opt_byte), .fully_active_state(fully_active_state),
        .rx_head_upd(rx_head_upd), .rx_head_in(rx_head_in), .rx_tail_upd(rx_tail_upd),
        .rx_tail_in(rx_tail_in), .rx_ptr_save(rx_ptr_save), .rx_ptr_restore(rx_ptr_restore),
        .rx_pkt_inc(rx_pkt_inc), .rx_pkt_dec(rx_pkt_dec), .tx_head_upd(tx_head_upd),
        .tx_head_in(tx_head_in), .alloc_reload(alloc_reload),
        .rx_allocation_size(rx_allocation_size), .rx_head(rx_head), .rx_tail(rx_tail),
        .rx_packet_count(rx_packet_count), .tx_head(tx_head),
        .phy_slowest_link(phy_slowest_link), .phy_gigabit_disable(phy_gigabit_disable),
        .phy_autoneg_restart(phy_autoneg_restart), .phy_pause_sym(phy_pause_sym),
        .phy_pause_asym(phy_pause_asym), .line_driver_class(line_driver_class),
        .flash_auto_update_disable(flash_auto_update_disable)
    );

    always #50 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic wait_ack();
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    endtask

    task automatic bus_wr(input logic [17:0] ofs, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= ofs[17:2];
        avs_writedata <= d;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    // Expected value is queued; the watcher compares when the answer arrives
    task automatic bus_rd(input logic [17:0] ofs, input logic [31:0] exp);
        exp_q.push_back(exp);
        name_q.push_back($sformatf("read %h", ofs));
        @(posedge mclk);
        avs_address <= ofs[17:2];
        avs_read <= 1'b1;
        wait_ack();
        avs_read <= 1'b0;
    endtask

    task automatic settle();
        @(posedge mclk);
        #1;
    endtask

    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(name_q.pop_front(), avs_readdata, exp_q.pop_front());
        end
    end

    initial begin
        #1_000_000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        settle();
        check("pause sym", phy_pause_sym, 32'h1);
        check("pause asym", phy_pause_asym, 32'h1);
        check("slowest", phy_slowest_link, 32'h0);
        check("gig off", phy_gigabit_disable, 32'h0);
        bus_rd(`OFS_PHY_OPT, {22'h0, `PO_RST});
        foreach (ofs_tab[i]) bus_rd(ofs_tab[i], rst_tab[i]);
        // Random data with reserved bits set; readback keeps 13 bits only
        foreach (ofs_tab[i]) begin
            v[i] = rnd();
            bus_wr(ofs_tab[i], v[i]);
            bus_rd(ofs_tab[i], v[i] & 32'h0000_1FFF);
        end
        #1;
        check("rx_head", {19'h0, rx_head}, v[0] & 32'h0000_1FFF);
        check("rx_tail", {19'h0, rx_tail}, v[1] & 32'h0000_1FFF);
        check("pkt count", {19'h0, rx_packet_count}, v[4] & 32'h0000_1FFF);
        check("tx_head", {19'h0, tx_head}, v[5] & 32'h0000_1FFF);
        for (int i = 0; i < 3; i++) begin
            a = rnd();
            bus_wr(alias_tab[i], a);
            bus_rd(prim_tab[i], a & 32'h0000_1FFF);
            bus_wr(prim_tab[i], ~a);
            bus_rd(alias_tab[i], ~a & 32'h0000_1FFF);
        end
        // Save live pointers, move them, then restore
        a = rnd();
        b = rnd();
        @(posedge mclk);
        rx_head_upd <= 1'b1;
        rx_head_in <= a[12:0];
        rx_tail_upd <= 1'b1;
        rx_tail_in <= b[12:0];
        @(posedge mclk);
        rx_ptr_save <= 1'b1;
        rx_head_in <= ~a[12:0];
        rx_tail_in <= ~b[12:0];
        @(posedge mclk);
        rx_ptr_save <= 1'b0;
        rx_head_upd <= 1'b0;
        rx_tail_upd <= 1'b0;
        #1;
        check("rx_head upd", {19'h0, rx_head}, {19'h0, ~a[12:0]});
        check("rx_tail upd", {19'h0, rx_tail}, {19'h0, ~b[12:0]});
        bus_rd(`OFS_RXHS, a & 32'h0000_1FFF);
        bus_rd(`OFS_RXTS, b & 32'h0000_1FFF);
        @(posedge mclk);
        rx_ptr_restore <= 1'b1;
        @(posedge mclk);
        rx_ptr_restore <= 1'b0;
        #1;
        check("rx_head restore", {19'h0, rx_head}, a & 32'h0000_1FFF);
        check("rx_tail restore", {19'h0, rx_tail}, b & 32'h0000_1FFF);
        // Count continues from the written value and wraps at 13 bits
        bus_wr(`OFS_RXPC, 32'h0000_1FFE);
        rx_pkt_inc <= 1'b1;
        repeat (2) @(posedge mclk);
        rx_pkt_inc <= 1'b0;
        rx_pkt_dec <= 1'b1;
        @(posedge mclk);
        rx_pkt_inc <= 1'b1;
        @(posedge mclk);
        rx_pkt_inc <= 1'b0;
        rx_pkt_dec <= 1'b0;
        bus_rd(`OFS_RXPC, 32'h0000_1FFF);
        for (int i = 0; i < 3; i++) begin
            sz = (i == 0) ? 6'h3F : (i == 1) ? `RXA_DEFAULT : 6'(rnd());
            @(posedge mclk);
            alloc_reload <= 1'b1;
            rx_allocation_size <= sz;
            tx_head_upd <= 1'b1;
            tx_head_in <= 13'(rnd());
            @(posedge mclk);
            alloc_reload <= 1'b0;
            tx_head_upd <= 1'b0;
            #1;
            check("tx_head reload", {19'h0, tx_head}, 32'(sz) * `RXA_SCALE);
        end
        // Option bits across both power states, with and without a restart command
        for (int i = 0; i < 12; i++) begin
            w = rnd();
            w[5] = i[0];
            @(posedge mclk);
            fully_active_state <= w[31];
            bus_wr(`OFS_PHY_OPT, w);
            #1;
            check("restart", phy_autoneg_restart, {31'h0, w[5]});
            settle();
            check("restart end", phy_autoneg_restart, 32'h0);
            check("slowest", phy_slowest_link, {31'h0, w[1] | (w[2] & ~w[31])});
            check("gig off", phy_gigabit_disable, {31'h0, w[6] | (w[3] & ~w[31])});
            check("flash upd", flash_auto_update_disable, {31'h0, w[7]});
            check("pause sym", phy_pause_sym, {31'h0, w[8]});
            check("pause asym", phy_pause_asym, {31'h0, w[9]});
            check("drv class", line_driver_class, {31'h0, w[4]});
            bus_rd(`OFS_PHY_OPT, w & 32'h0000_03DF);
            // Settings have stood for more than 80 ns; commit them with a restart
            bus_wr(`OFS_PHY_OPT, w | 32'h0000_0020);
            #1;
            check("restart commit", phy_autoneg_restart, 32'h1);
        end
        b = rnd();
        @(posedge mclk);
        nvm_load <= 1'b1;
        nvm_opt_byte <= 8'hFF ^ b[7:0];
        @(posedge mclk);
        nvm_load <= 1'b0;
        bus_rd(`OFS_PHY_OPT, {22'h0, w[9:8], (8'hFF ^ b[7:0]) & 8'hDF});
        // A hole in the map reads zero and ignores writes
        bus_wr(18'h02414, 32'hFFFF_FFFF);
        bus_rd(18'h02414, 32'h0000_0000);
        bus_rd(`OFS_RXH, a & 32'h0000_1FFF);
        // Lane 1 only: bits 12:8 cleared, low byte kept
        avs_byteenable <= 4'h2;
        bus_wr(`OFS_RXH, 32'h0000_0000);
        avs_byteenable <= 4'hF;
        bus_rd(`OFS_RXH, a & 32'h0000_00FF);
        wait (exp_q.size() == 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
